// ===== clock_mode_pkg.sv
// constants and types shared by the clock and power-mode controller
package clock_mode_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CLOCK_MODE_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] CONTROL_EXTRA_ADDR      = 8'h04;
  localparam logic [7:0] IRQ_STATUS_ADDR         = 8'h08;
  localparam logic [7:0] IRQ_MASK_ADDR           = 8'h0c;

  // ----------------------------------------------------------------
  // clock_mode_control field positions and reset
  // ----------------------------------------------------------------
  localparam int DIV_SEL_LSB      = 5;
  localparam int FAST_WAKE_BIT    = 4;
  localparam int LOW_READY_BIT    = 3;
  localparam int HIGH_READY_BIT   = 2;
  localparam int IDLE_ON_HALT_BIT = 1;
  localparam int HIGH_SEL_BIT     = 0;
  localparam logic [7:0] CLOCK_MODE_CONTROL_RESET = 8'h03;

  // control_extra field positions and reset
  localparam int KEEP_SYSCLK_BIT = 0;
  localparam int WDT_EN_BIT      = 1;
  localparam int LVD_EN_BIT      = 2;
  localparam logic [2:0] CONTROL_EXTRA_RESET = 3'h2;

  // interrupt event bits
  localparam int EV_HIGH_READY = 0;
  localparam int EV_LOW_READY  = 1;
  localparam int EV_WAKE       = 2;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // ----------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------
  localparam int          OSC_STABLE_CYCLES = 1024;
  localparam logic [10:0] OSC_STABLE_COUNT  = 11'(OSC_STABLE_CYCLES);
  localparam logic [1:0]  SLOW_READY_EDGES  = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RUN, IDLE_CLOCK_OFF, IDLE_CLOCK_ON, SLEEP_ALL_OFF, SLEEP_SUB_ON
  } power_mode_type;

  typedef struct packed {
    logic [2:0] sysclkDivSel;
    logic       fastWakeEn;
    logic       idleOnHalt;
    logic       highClockSel;
    logic       keepSysclkInIdle;
    logic       watchdogEn;
    logic       lowVoltageDetectEn;
  } clock_config_type;

endpackage

// ===== system_clock_mode_control.sv
// system clock selection and power-mode controller with an apb slave
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/10ps

module system_clock_mode_control #(
  parameter bit FAST_SOURCE_IS_CRYSTAL = 1'b1
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // oscillator pins, sampled
  input  wire logic        highOscPin,
  input  wire logic        slowOscPin,
  // cpu events
  input  wire logic        haltExec,
  input  wire logic        wakeEvent,
  // clock and mode outputs
  output logic             sysClockEn,
  output logic             highOscEnable,
  output logic             slowOscEnable,
  output logic             subClockEn,
  output logic             cpuRun,
  output logic [2:0]       powerMode,
  output logic             irq
);

  // ----------------------------------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [2:0] highSync;
  logic [2:0] slowSync;
  logic       highState;
  logic       slowState;

  // three-stage capture of the free-running oscillator pins
  always_ff @(posedge clk_sys) begin
    highSync <= {highSync[1:0], highOscPin};
  end

  always_ff @(posedge clk_sys) begin
    slowSync <= {slowSync[1:0], slowOscPin};
  end

  wire highAgree = highSync[1] == highSync[2];
  wire slowAgree = slowSync[1] == slowSync[2];
  wire highRise  = highAgree && highSync[2] && !highState;
  wire slowRise  = slowAgree && slowSync[2] && !slowState;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      highState <= 1'b0;
      slowState <= 1'b0;
    end else begin
      if (highAgree) highState <= highSync[2];
      if (slowAgree) slowState <= slowSync[2];
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  clock_mode_pkg::clock_config_type cfg;
  clock_mode_pkg::power_mode_type   mode;
  clock_mode_pkg::power_mode_type   next_mode;
  logic        highReady;
  logic        lowReady;
  logic [10:0] highCount;
  logic [1:0]  slowCount;
  logic        fastWaking;
  logic [2:0]  irqStatus;
  logic [2:0]  irqMask;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire access    = psel && penable;
  wire hitMode   = paddr == clock_mode_pkg::CLOCK_MODE_CONTROL_ADDR;
  wire hitExtra  = paddr == clock_mode_pkg::CONTROL_EXTRA_ADDR;
  wire hitStatus = paddr == clock_mode_pkg::IRQ_STATUS_ADDR;
  wire hitMask   = paddr == clock_mode_pkg::IRQ_MASK_ADDR;
  wire hitAny    = hitMode || hitExtra || hitStatus || hitMask;
  wire writeMode  = access && pwrite && hitMode;
  wire writeExtra = access && pwrite && hitExtra;
  wire writeMask  = access && pwrite && hitMask;
  wire readStatus = access && !pwrite && hitStatus;

  wire [7:0] modeReadValue = {cfg.sysclkDivSel, cfg.fastWakeEn, lowReady,
                              highReady, cfg.idleOnHalt, cfg.highClockSel};
  wire [2:0] extraReadValue = {cfg.lowVoltageDetectEn, cfg.watchdogEn,
                               cfg.keepSysclkInIdle};
  wire [31:0] modeWord   = {24'h000000, modeReadValue};
  wire [31:0] extraWord  = {29'h00000000, extraReadValue};
  wire [31:0] statusWord = {29'h00000000, irqStatus};
  wire [31:0] maskWord   = {29'h00000000, irqMask};

  // unmapped addresses read as zero
  wire [31:0] readValue =
    hitMode   ? modeWord :
    hitExtra  ? extraWord :
    hitStatus ? statusWord :
    hitMask   ? maskWord : 32'h00000000;

  assign pready  = 1'b1;
  assign pslverr = access && !hitAny;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite) prdata <= readValue;
  end

  // configuration writes; ready bit positions are ignored
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      {cfg.sysclkDivSel, cfg.fastWakeEn} <= clock_mode_pkg::CLOCK_MODE_CONTROL_RESET[7:4];
      cfg.idleOnHalt   <= clock_mode_pkg::CLOCK_MODE_CONTROL_RESET[1];
      cfg.highClockSel <= clock_mode_pkg::CLOCK_MODE_CONTROL_RESET[0];
      {cfg.lowVoltageDetectEn, cfg.watchdogEn, cfg.keepSysclkInIdle} <=
        clock_mode_pkg::CONTROL_EXTRA_RESET;
      irqMask <= clock_mode_pkg::IRQ_MASK_RESET;
    end else begin
      if (writeMode) begin
        cfg.sysclkDivSel <= pwdata[clock_mode_pkg::DIV_SEL_LSB +: 3];
        cfg.fastWakeEn   <= pwdata[clock_mode_pkg::FAST_WAKE_BIT];
        cfg.idleOnHalt   <= pwdata[clock_mode_pkg::IDLE_ON_HALT_BIT];
        cfg.highClockSel <= pwdata[clock_mode_pkg::HIGH_SEL_BIT];
      end
      if (writeExtra) begin
        cfg.keepSysclkInIdle   <= pwdata[clock_mode_pkg::KEEP_SYSCLK_BIT];
        cfg.watchdogEn         <= pwdata[clock_mode_pkg::WDT_EN_BIT];
        cfg.lowVoltageDetectEn <= pwdata[clock_mode_pkg::LVD_EN_BIT];
      end
      if (writeMask) irqMask <= pwdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // clock source selection
  // ----------------------------------------------------------------
  wire selLow    = !cfg.highClockSel && (cfg.sysclkDivSel[2:1] == 2'b00);
  wire [2:0] divShift = cfg.highClockSel ? 3'h0 : 3'(3'h7 - cfg.sysclkDivSel + 3'h1);
  wire wakeMode  = (mode == clock_mode_pkg::IDLE_CLOCK_OFF) ||
                   (mode == clock_mode_pkg::SLEEP_SUB_ON) ||
                   (mode == clock_mode_pkg::SLEEP_ALL_OFF);
  wire crystalFast = FAST_SOURCE_IS_CRYSTAL && cfg.fastWakeEn;
  wire runOnLow  = selLow || fastWaking;

  // ----------------------------------------------------------------
  // power mode machine
  // ----------------------------------------------------------------
  always_comb begin
    next_mode = mode;
    case (mode)
      clock_mode_pkg::RUN: begin
        if (haltExec) begin
          if (cfg.idleOnHalt && !cfg.keepSysclkInIdle)
            next_mode = clock_mode_pkg::IDLE_CLOCK_OFF;
          else if (cfg.idleOnHalt)
            next_mode = clock_mode_pkg::IDLE_CLOCK_ON;
          else if (cfg.lowVoltageDetectEn || cfg.watchdogEn)
            next_mode = clock_mode_pkg::SLEEP_SUB_ON;
          else
            next_mode = clock_mode_pkg::SLEEP_ALL_OFF;
        end
      end
      clock_mode_pkg::IDLE_CLOCK_OFF,
      clock_mode_pkg::IDLE_CLOCK_ON,
      clock_mode_pkg::SLEEP_ALL_OFF,
      clock_mode_pkg::SLEEP_SUB_ON: begin
        // any halted mode returns to run on a wake request
        if (wakeEvent) begin
          next_mode = clock_mode_pkg::RUN;
        end
      end
      default: begin
        next_mode = clock_mode_pkg::RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) mode <= clock_mode_pkg::RUN;
    else mode <= next_mode;
  end

  wire waking = (mode != clock_mode_pkg::RUN) && (next_mode == clock_mode_pkg::RUN);

  // fast wake: low clock runs until crystal stable
  always_ff @(posedge clk_sys) begin
    if (sys_rst) fastWaking <= 1'b0;
    else if (waking && crystalFast && wakeMode && mode != clock_mode_pkg::SLEEP_ALL_OFF
             && !selLow)
      fastWaking <= 1'b1;
    else if (highRise && highCount == clock_mode_pkg::OSC_STABLE_COUNT - 11'h001)
      fastWaking <= 1'b0;
  end

  // ----------------------------------------------------------------
  // oscillator enables
  // ----------------------------------------------------------------
  wire running = mode == clock_mode_pkg::RUN;
  assign highOscEnable = (running && !selLow) ||
                         (mode == clock_mode_pkg::IDLE_CLOCK_ON && !selLow);
  assign slowOscEnable = (running && runOnLow) || cfg.watchdogEn ||
                         cfg.lowVoltageDetectEn ||
                         (mode == clock_mode_pkg::IDLE_CLOCK_ON && selLow);
  assign subClockEn    = (mode != clock_mode_pkg::SLEEP_ALL_OFF) &&
                         (mode != clock_mode_pkg::SLEEP_SUB_ON ||
                          cfg.lowVoltageDetectEn || cfg.watchdogEn);
  assign cpuRun    = running;
  assign powerMode = mode;

  // ----------------------------------------------------------------
  // ready flags
  // ----------------------------------------------------------------
  wire highStop = !highOscEnable;
  wire lowStop  = mode == clock_mode_pkg::SLEEP_ALL_OFF;
  wire highDone = highRise && highCount == clock_mode_pkg::OSC_STABLE_COUNT - 11'h001;
  wire lowDone  = slowRise && slowCount == clock_mode_pkg::SLOW_READY_EDGES - 2'h1;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      highReady <= 1'b0;
      highCount <= 11'h000;
    end else if (highStop) begin
      highReady <= 1'b0;
      highCount <= 11'h000;
    end else if (!highReady && highRise) begin
      highCount <= highCount + 11'h001;
      if (highDone) highReady <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || lowStop) begin
      lowReady  <= 1'b0;
      slowCount <= 2'h0;
    end else if (!lowReady && slowRise) begin
      slowCount <= slowCount + 2'h1;
      if (lowDone) lowReady <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // glitch-free system clock enable, divided from high oscillator, or taken from slow oscillator edges when running on low
  // ----------------------------------------------------------------
  logic [5:0] divCount;
  wire [5:0] divMask = 6'((7'h01 << divShift) - 7'h01);
  wire highTick = highRise && ((divCount & divMask) == divMask);

  always_ff @(posedge clk_sys) begin
    if (sys_rst || highStop) divCount <= 6'h00;
    else if (highRise) divCount <= divCount + 6'h01;
  end

  wire clockOn = running || mode == clock_mode_pkg::IDLE_CLOCK_ON;
  wire next_sysClockEn = clockOn &&
    (runOnLow ? (slowRise && lowReady) : (highTick && highReady));

  always_ff @(posedge clk_sys) begin
    if (sys_rst) sysClockEn <= 1'b0;
    else sysClockEn <= next_sysClockEn;
  end

  // ----------------------------------------------------------------
  // interrupts: sticky status, clear on read, set wins
  // ----------------------------------------------------------------
  wire [2:0] events = {waking, lowDone && !lowReady, highDone && !highReady && !highStop};

  // only bits already returned in prdata are cleared, so an event that
  // lands between setup and access is kept for the next read
  wire [2:0] readBits  = readStatus ? prdata[2:0] : 3'h0;
  wire [2:0] keptBits  = irqStatus & ~readBits;
  wire [2:0] next_irqStatus = keptBits | events;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) irqStatus <= 3'h0;
    else irqStatus <= next_irqStatus;
  end

  assign irq = |(irqStatus & irqMask);

endmodule // system_clock_mode_control

// ===== system_clock_mode_control_assertions.sv
// concurrent checks on the clock and power-mode controller ports
`timescale 1ns/10ps

module system_clock_mode_control_checker (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // mode side
  input wire logic        haltExec,
  input wire logic        sysClockEn,
  input wire logic        highOscEnable,
  input wire logic        slowOscEnable,
  input wire logic        subClockEn,
  input wire logic        cpuRun,
  input wire logic [2:0]  powerMode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence rdCtrl;
    psel && !penable && !pwrite && paddr == clock_mode_pkg::CLOCK_MODE_CONTROL_ADDR;
  endsequence
  sequence clkOff;
    powerMode == 3'h1 || powerMode == 3'h3 || powerMode == 3'h4;
  endsequence
  sequence allOff;
    powerMode == 3'h3;
  endsequence
  sequence slowWrite;
    psel && penable && pwrite && paddr == 8'h00 && !pwdata[0] && pwdata[7:6] == 2'h0;
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_HALT_STOPS_CPU: assert property (cpuRun && haltExec |=> !cpuRun)
    else $error("halt in run did not stop the cpu");
  AST_IDLE_OFF_CLOCKS: assert property (powerMode == 3'h1 |-> !highOscEnable && subClockEn)
    else $error("idle clock off has wrong clocks");
  AST_IDLE_ON_SUB: assert property (powerMode == 3'h2 |-> subClockEn)
    else $error("idle clock on lost the sub clock");
  AST_SLEEP_ALL_OFF: assert property (allOff |-> !subClockEn && !slowOscEnable)
    else $error("sleep all off left a clock running");
  AST_SLEEP_SUB_ON: assert property (powerMode == 3'h4 |-> subClockEn && !highOscEnable)
    else $error("sleep sub on has wrong clocks");
  AST_NO_TICK_HALTED: assert property (clkOff [*2] |-> !sysClockEn)
    else $error("system clock ticks while stopped");
  AST_LOW_READY_SLEEP: assert property (allOff [*2] ##0 rdCtrl |=> !prdata[3])
    else $error("low ready read high in sleep all off");
  AST_HIGH_READY_HALTED: assert property (clkOff [*2] ##0 rdCtrl |=> !prdata[2])
    else $error("high ready read high while stopped");
  AST_SLOW_HIGH_OFF: assert property (slowWrite ##1 cpuRun [*3] |-> !highOscEnable)
    else $error("high oscillator runs in slow mode");
endmodule // system_clock_mode_control_checker

bind system_clock_mode_control system_clock_mode_control_checker checker_i (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .haltExec(haltExec),
  .sysClockEn(sysClockEn), .highOscEnable(highOscEnable), .slowOscEnable(slowOscEnable),
  .subClockEn(subClockEn), .cpuRun(cpuRun), .powerMode(powerMode)
);

// ===== system_clock_mode_control_tb.sv
// self-checking testbench for the clock and power-mode controller
`timescale 1ns/10ps

module system_clock_mode_control_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        highOscPin = 1'b0;
  logic        slowOscPin = 1'b0;
  logic        haltExec = 1'b0;
  logic        wakeEvent = 1'b0;
  logic        pready, pslverr, sysClockEn, highOscEnable, slowOscEnable, subClockEn;
  logic        cpuRun, irq, err;
  logic [31:0] prdata, rd;
  logic [2:0]  powerMode;
  logic [7:0]  oscCnt = 8'h00;
  int          num_errors = 0;
  int          check_count = 0;
  int          n;
  // halt cases: control word, extra bits, mode code, sub clock
  localparam logic [7:0] CTL [5] = '{8'h03, 8'h03, 8'h01, 8'h01, 8'h01};
  localparam logic [2:0] EXT [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h0};
  localparam logic [2:0] MD [5]  = '{3'h1, 3'h2, 3'h4, 3'h4, 3'h3};
  localparam logic [4:0] SUBV    = 5'b01111;

  always #50 clk_sys = ~clk_sys;

  // oscillator waveforms, four clocks per high half period
  always @(posedge clk_sys) begin
    oscCnt     <= oscCnt + 8'h01;
    highOscPin <= oscCnt[2];
    slowOscPin <= oscCnt[4];
  end

  system_clock_mode_control system_clock_mode_control_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .highOscPin(highOscPin), .slowOscPin(slowOscPin), .haltExec(haltExec),
    .wakeEvent(wakeEvent), .sysClockEn(sysClockEn), .highOscEnable(highOscEnable),
    .slowOscEnable(slowOscEnable), .subClockEn(subClockEn), .cpuRun(cpuRun),
    .powerMode(powerMode), .irq(irq)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse(input logic isHalt);
    @(posedge clk_sys);
    haltExec  <= isHalt;
    wakeEvent <= !isHalt;
    @(posedge clk_sys);
    haltExec  <= 1'b0;
    wakeEvent <= 1'b0;
    #1;
  endtask

  task automatic test_done;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequence of tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h03);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h02);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    repeat (64) @(posedge clk_sys);
    chk(32'(irq), 32'h0);
    apb(1'b1, 8'h0c, 32'h7);
    #1;
    chk(32'(irq), 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h2);
    #1;
    chk(32'(irq), 32'h0);
    for (n = 0; n < 12000 && irq !== 1'b1; n++) @(posedge clk_sys);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0f);
    apb(1'b1, 8'h00, 32'hf3);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'hff);
    apb(1'b1, 8'h00, 32'h02);
    repeat (3) @(posedge clk_sys);
    chk({highOscEnable, cpuRun}, 32'h1);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 8'h04, 32'(EXT[i]));
      apb(1'b1, 8'h00, 32'(CTL[i]));
      pulse(1'b1);
      chk(32'(powerMode), 32'(MD[i]));
      chk({cpuRun, subClockEn}, 32'(SUBV[i]));
      repeat (2) @(posedge clk_sys);
      apb(1'b0, 8'h00, 32'h0);
      if (MD[i] != 3'h2) chk(32'(rd[2]), 32'h0);
      if (MD[i] == 3'h3) chk(32'(rd[3]), 32'h0);
      pulse(1'b0);
      chk(32'(powerMode), 32'h0);
    end
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h00, 32'h13);
    pulse(1'b1);
    pulse(1'b0);
    for (n = 0; n < 200 && sysClockEn !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(32'(sysClockEn), 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk(32'(rd[2]), 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk(32'(rd[2]), 32'h1);
    test_done();
  end

  // watchdog on a hung run
  initial begin
    repeat (30000) @(posedge clk_sys);
    num_errors++;
    test_done();
  end
endmodule // system_clock_mode_control_tb
